// ### rtl/asq_averager.sv
// Shared power-of-two averager between converter and result buffers.
// Assumes one sample pulse at a time and a stable factor per slot.
`include "asq_cfg.svh"

module asq_averager
    import asq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic clear,
    input wire logic in_vld,
    input wire asq_sample_t in_data,
    input wire logic [2:0] log2_n,
    output logic out_vld_q,
    output asq_sample_t out_data_q
);
    // ****************************************************************
    // Accumulator
    // ****************************************************************
    logic [15:0] acc_q;
    logic [6:0] cnt_q;
    logic [2:0] shift;
    logic [6:0] last_cnt;
    logic [15:0] sum;

    assign shift = (log2_n > `ASQ_AVG_MAX_LOG2) ? `ASQ_AVG_MAX_LOG2 : log2_n;
    assign last_cnt = (7'h01 << shift) - 7'h01;
    assign sum = acc_q + 16'(in_data);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_q <= '0;
            cnt_q <= '0;
            out_vld_q <= 1'b0;
            out_data_q <= '0;
        end else if (ce) begin
            out_vld_q <= 1'b0;
            if (clear) begin
                acc_q <= '0;
                cnt_q <= '0;
            end else if (in_vld && cnt_q == last_cnt) begin
                out_data_q <= `ASQ_RES_W'(sum >> shift);
                out_vld_q <= 1'b1;
                acc_q <= '0;
                cnt_q <= '0;
            end else if (in_vld) begin
                acc_q <= sum;
                cnt_q <= cnt_q + 7'h01;
            end
        end
    end
endmodule

// ### rtl/asq_cfg.svh
// Constants for the sample sequencer control block.
// Assumes inclusion by bare name from the rtl folder.
`ifndef ASQ_CFG_SVH
`define ASQ_CFG_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define ASQ_NUM_SEQ 4
`define ASQ_DEPTH0 8
`define ASQ_DEPTH1 4
`define ASQ_DEPTH2 4
`define ASQ_DEPTH3 1
`define ASQ_MAX_SLOTS 8
`define ASQ_RES_W 10
`define ASQ_WORD_W 32
`define ASQ_NIB_W 4

// ****************************************************************
// Control nibble fields
// ****************************************************************
`define ASQ_CTL_DIFF 0
`define ASQ_CTL_END 1
`define ASQ_CTL_IE 2
`define ASQ_CTL_TS 3

// ****************************************************************
// Trigger source codes, priority and averaging
// ****************************************************************
`define ASQ_TRIG_PROC 4'h0
`define ASQ_TRIG_EXT_FIRST 4'h1
`define ASQ_TRIG_EXT_LAST 4'h4
`define ASQ_TRIG_ALWAYS 4'hF
`define ASQ_PRI_RESET 16'h3210
`define ASQ_PRI_W 2
`define ASQ_AVG_MAX_LOG2 3'h6

// ****************************************************************
// Status word layout
// ****************************************************************
`define ASQ_STAT_TAIL_LSB 0
`define ASQ_STAT_HEAD_LSB 4
`define ASQ_STAT_EMPTY_BIT 8
`define ASQ_STAT_FULL_BIT 12

`endif

// ### rtl/asq_pkg.sv
// Types shared by the sample sequencer control block.
// Assumes asq_cfg.svh is reachable by bare name.
`include "asq_cfg.svh"

package asq_pkg;
    typedef logic [`ASQ_RES_W-1:0] asq_sample_t;
    typedef enum logic [3:0] {
        ASQ_IDLE = 4'b0001,
        ASQ_CONV = 4'b0010,
        ASQ_WAIT = 4'b0100,
        ASQ_AVG  = 4'b1000
    } asq_state_e;
endpackage

// ### rtl/asq_result_fifo.sv
// Circular result buffer for one sequencer.
// Assumes single clock, push and pop from the control top.
`include "asq_cfg.svh"

module asq_result_fifo
    import asq_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int W = `ASQ_RES_W,
    parameter int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic push,
    input wire logic [W-1:0] push_data,
    input wire logic pop,
    output logic [W-1:0] rd_data_q,
    output logic full,
    output logic empty,
    output logic [PW-1:0] head_q,
    output logic [PW-1:0] tail_q,
    output logic overflow,
    output logic underflow
);
    // ****************************************************************
    // Storage and pointers
    // ****************************************************************
    logic [W-1:0] mem_q [DEPTH];
    logic [PW:0] cnt_q;
    logic push_ok;
    logic pop_ok;

    assign full = (cnt_q == (PW+1)'(DEPTH));
    assign empty = (cnt_q == '0);
    assign push_ok = push & ~full;
    assign pop_ok = pop & ~empty;
    assign overflow = push & full;
    assign underflow = pop & empty;

    function automatic logic [PW-1:0] wrap_inc(input logic [PW-1:0] p);
        wrap_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            head_q <= '0;
            tail_q <= '0;
            cnt_q <= '0;
            rd_data_q <= '0;
        end else if (ce) begin
            if (push_ok) begin
                tail_q <= wrap_inc(tail_q);
            end
            if (pop_ok) begin
                head_q <= wrap_inc(head_q);
                rd_data_q <= mem_q[head_q];
            end
            cnt_q <= cnt_q + (PW+1)'(push_ok) - (PW+1)'(pop_ok);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (ce && push_ok) begin
            mem_q[tail_q] <= push_data;
        end
    end
endmodule

// ### rtl/asq_sequencer_top.sv
// Sample sequencer control: triggers, arbitration, slots, buffers, status.
// Assumes the converter core shares ref_clk and steady config while enabled.
//
// What this block does
// - Four sequencers, slot and buffer depths eight, four, four and one.
// - Result words are 32 bits with the result in the low ten.
// - Each slot has an input nibble and a control nibble.
// - Control nibble holds temp sensor, interrupt enable, end, differential.
// - Sequencers run only when enabled; settings writable while disabled.
// - One input may appear in many slots of a sequence.
// - Per-slot interrupt enable, any combination of slots.
// - End flag in any slot finishes the sequence after that slot.
// - Each result buffer is circular; each read pops the oldest.
// - Head, tail, full and empty visible per buffer.
// - Overflow and underflow kept in separate status words.
// - Raw and masked interrupt status; only masked ones drive irq.
// - Writing one clears an interrupt bit; zero does nothing.
// - Coinciding triggers served by priority value, zero highest.
// - Per-sequencer trigger select incl. processor and always sources.
// - Processor initiate bit starts a processor-triggered sequencer.
// - Always trigger keeps requesting and may starve lower priorities.
// - Averager folds up to 64 conversions into one entry.
// - Averaging off at reset; one factor for all inputs.
// - Loopback mode drives sequencing and buffers without the converter.
// - Control runs from the converter clock near 10 MHz.
// - Priority resets to 3210, sequencer zero highest.
// - Enable bits 3..0 activate their sequencers.
`include "asq_cfg.svh"

module asq_sequencer_top
    import asq_pkg::*;
#(
    parameter int NSEQ = `ASQ_NUM_SEQ
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] active_sequencer_enable,
    input wire logic [3:0] irq_mask_reg,
    input wire logic [15:0] trigger_event_select,
    input wire logic [3:0][31:0] seq_input_select,
    input wire logic [3:0][31:0] seq_sample_control,
    input wire logic pri_wr,
    input wire logic [15:0] pri_wdata,
    input wire logic init_wr,
    input wire logic [3:0] processor_initiate,
    input wire logic irq_clr_wr,
    input wire logic [3:0] masked_irq_status_clear,
    input wire logic ovf_clr_wr,
    input wire logic [3:0] ovf_clr_bits,
    input wire logic udf_clr_wr,
    input wire logic [3:0] udf_clr_bits,
    input wire logic [2:0] averaging_control,
    input wire logic loopback_test_control,
    input wire logic [3:0] fifo_pop,
    input wire logic [3:0] ext_event,
    input wire logic conv_done,
    input wire asq_sample_t conv_data,
    output logic conv_start,
    output logic [3:0] conv_input_q,
    output logic conv_diff_q,
    output logic conv_temp_q,
    output logic [3:0][31:0] seq_result_fifo,
    output logic [3:0][31:0] seq_fifo_status_q,
    output logic [15:0] sequencer_priority_q,
    output logic [3:0] raw_irq_status_q,
    output logic [3:0] masked_irq_status_q,
    output logic irq_q,
    output logic [3:0] fifo_overflow_status_q,
    output logic [3:0] fifo_underflow_status_q,
    output logic busy
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [3:0] depth_of(input logic [1:0] s);
        case (s)
            2'd0: depth_of = 4'(`ASQ_DEPTH0);
            2'd1: depth_of = 4'(`ASQ_DEPTH1);
            2'd2: depth_of = 4'(`ASQ_DEPTH2);
            default: depth_of = 4'(`ASQ_DEPTH3);
        endcase
    endfunction

    function automatic logic [3:0] nib(input logic [31:0] w, input logic [2:0] s);
        nib = w[4*s +: 4];
    endfunction

    // ****************************************************************
    // External event synchronisers and edge detect
    // ****************************************************************
    logic [3:0] ev_s1_q, ev_s2_q, ev_s3_q, ev_rise;
    assign ev_rise = ev_s2_q & ~ev_s3_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ev_s1_q <= '0;
            ev_s2_q <= '0;
            ev_s3_q <= '0;
        end else if (ce) begin
            ev_s1_q <= ext_event;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
        end
    end

    // ****************************************************************
    // Triggers and pending requests
    // ****************************************************************
    asq_state_e state_q, state_d;
    logic [3:0] trig_hit, pend_q, grant_vec;
    logic grant;
    logic [1:0] best_seq, best_pri;

    for (genvar g = 0; g < NSEQ; g++) begin : g_trig
        logic [3:0] sel;
        logic ext_hit;
        assign sel = trigger_event_select[4*g +: 4];
        assign ext_hit = (sel >= `ASQ_TRIG_EXT_FIRST) && (sel <= `ASQ_TRIG_EXT_LAST)
            && ev_rise[2'(sel - `ASQ_TRIG_EXT_FIRST)];
        // Only enabled sequencers see triggers
        assign trig_hit[g] = active_sequencer_enable[g] & (
            ((sel == `ASQ_TRIG_PROC) & init_wr & processor_initiate[g])
            | (sel == `ASQ_TRIG_ALWAYS)
            | ext_hit);
    end

    // Lowest priority value wins; ties fall to lower index
    always_comb begin
        grant = 1'b0;
        best_seq = '0;
        best_pri = 2'd3;
        for (int i = 0; i < NSEQ; i++) begin
            if (pend_q[i] && active_sequencer_enable[i] && (!grant ||
                sequencer_priority_q[4*i +: `ASQ_PRI_W] < best_pri)) begin
                grant = 1'b1;
                best_seq = 2'(i);
                best_pri = sequencer_priority_q[4*i +: `ASQ_PRI_W];
            end
        end
        grant = grant & (state_q == ASQ_IDLE);
    end

    assign grant_vec = grant ? (4'h1 << best_seq) : 4'h0;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_q <= '0;
            sequencer_priority_q <= `ASQ_PRI_RESET;
        end else if (ce) begin
            // New trigger wins over the grant clear
            pend_q <= ((pend_q & ~grant_vec) | trig_hit) & active_sequencer_enable;
            if (pri_wr) begin
                sequencer_priority_q <= pri_wdata;
            end
        end
    end

    // ****************************************************************
    // Slot walk
    // ****************************************************************
    logic [1:0] cur_seq_q, load_seq;
    logic [2:0] slot_q, next_slot, load_slot;
    logic [3:0] cur_ctl_q, load_ctl;
    logic [4:0] lb_cnt_q;
    logic lb_q, aborted, last_slot, sample_vld, avg_vld, store, load;
    asq_sample_t sample_data, avg_data;

    assign aborted = (state_q != ASQ_IDLE) & ~active_sequencer_enable[cur_seq_q];
    // End flag or the sequencer's last slot closes the sequence
    assign last_slot = cur_ctl_q[`ASQ_CTL_END] ||
        ({1'b0, slot_q} == depth_of(cur_seq_q) - 4'h1);
    assign store = (state_q == ASQ_AVG) & avg_vld;
    assign next_slot = slot_q + 3'h1;
    assign load = grant | (store & ~last_slot);
    assign load_seq = grant ? best_seq : cur_seq_q;
    assign load_slot = grant ? 3'h0 : next_slot;
    assign load_ctl = nib(seq_sample_control[load_seq], load_slot);

    // Loopback supplies a tagged pattern instead of a conversion
    assign sample_vld = ((state_q == ASQ_CONV) & lb_q)
        | ((state_q == ASQ_WAIT) & conv_done & ~lb_q);
    assign sample_data = lb_q ? {cur_seq_q, slot_q, lb_cnt_q} : conv_data;
    assign conv_start = (state_q == ASQ_CONV) & ~lb_q & ~aborted;
    assign busy = (state_q != ASQ_IDLE);

    always_comb begin
        state_d = state_q;
        case (state_q)
            ASQ_IDLE: begin
                if (grant) begin
                    state_d = ASQ_CONV;
                end
            end
            ASQ_CONV: begin
                state_d = lb_q ? ASQ_AVG : ASQ_WAIT;
            end
            ASQ_WAIT: begin
                if (conv_done) begin
                    state_d = ASQ_AVG;
                end
            end
            ASQ_AVG: begin
                if (!avg_vld) begin
                    state_d = ASQ_CONV;
                end else if (last_slot) begin
                    state_d = ASQ_IDLE;
                end else begin
                    state_d = ASQ_CONV;
                end
            end
            default: begin
                state_d = ASQ_IDLE;
            end
        endcase
        if (aborted) begin
            state_d = ASQ_IDLE;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ASQ_IDLE;
            cur_seq_q <= '0;
            slot_q <= '0;
            cur_ctl_q <= '0;
            conv_input_q <= '0;
            conv_diff_q <= 1'b0;
            conv_temp_q <= 1'b0;
            lb_cnt_q <= '0;
            lb_q <= 1'b0;
        end else if (ce) begin
            state_q <= state_d;
            if (grant) begin
                lb_q <= loopback_test_control;
            end
            if (sample_vld && lb_q) begin
                lb_cnt_q <= lb_cnt_q + 5'h01;
            end
            // Fetch the slot's two nibbles
            if (load) begin
                cur_seq_q <= load_seq;
                slot_q <= load_slot;
                cur_ctl_q <= load_ctl;
                conv_input_q <= nib(seq_input_select[load_seq], load_slot);
                conv_diff_q <= load_ctl[`ASQ_CTL_DIFF];
                conv_temp_q <= load_ctl[`ASQ_CTL_TS];
            end
        end
    end

    // One shared averager, same factor for every input
    asq_averager u_avg (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .clear(aborted | grant),
        .in_vld(sample_vld),
        .in_data(sample_data),
        .log2_n(averaging_control),
        .out_vld_q(avg_vld),
        .out_data_q(avg_data)
    );

    // ****************************************************************
    // Result buffers
    // ****************************************************************
    logic [3:0] ovf_ev, udf_ev, irq_set;

    for (genvar g = 0; g < NSEQ; g++) begin : g_fifo
        localparam int DEP = (g == 0) ? `ASQ_DEPTH0 : (g == 1) ? `ASQ_DEPTH1 :
            (g == 2) ? `ASQ_DEPTH2 : `ASQ_DEPTH3;
        localparam int PW = (DEP > 1) ? $clog2(DEP) : 1;
        asq_sample_t rd;
        logic full, empty, push;
        logic [PW-1:0] head, tail;

        assign push = store & (cur_seq_q == 2'(g));
        assign irq_set[g] = push & cur_ctl_q[`ASQ_CTL_IE];

        // Circular buffer, pop returns oldest
        asq_result_fifo #(.DEPTH(DEP), .W(`ASQ_RES_W), .PW(PW)) u_fifo (
            .ref_clk(ref_clk),
            .rst(rst),
            .ce(ce),
            .push(push),
            .push_data(avg_data),
            .pop(fifo_pop[g]),
            .rd_data_q(rd),
            .full(full),
            .empty(empty),
            .head_q(head),
            .tail_q(tail),
            .overflow(ovf_ev[g]),
            .underflow(udf_ev[g])
        );

        assign seq_result_fifo[g] = {{(`ASQ_WORD_W - `ASQ_RES_W){1'b0}}, rd};

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                seq_fifo_status_q[g] <= '0;
            end else if (ce) begin
                // Pointers and flags mirrored one cycle later
                seq_fifo_status_q[g] <= (32'(head) << `ASQ_STAT_HEAD_LSB)
                    | (32'(tail) << `ASQ_STAT_TAIL_LSB)
                    | (32'(empty) << `ASQ_STAT_EMPTY_BIT)
                    | (32'(full) << `ASQ_STAT_FULL_BIT);
            end
        end
    end

    // ****************************************************************
    // Sticky status and interrupt
    // ****************************************************************
    logic [3:0] irq_clr, ovf_clr, udf_clr, raw_d;

    assign irq_clr = irq_clr_wr ? masked_irq_status_clear : 4'h0;
    assign ovf_clr = ovf_clr_wr ? ovf_clr_bits : 4'h0;
    assign udf_clr = udf_clr_wr ? udf_clr_bits : 4'h0;
    assign raw_d = (raw_irq_status_q & ~irq_clr) | irq_set;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            raw_irq_status_q <= '0;
            masked_irq_status_q <= '0;
            irq_q <= 1'b0;
            fifo_overflow_status_q <= '0;
            fifo_underflow_status_q <= '0;
        end else if (ce) begin
            raw_irq_status_q <= raw_d;
            // Masked view and line follow raw status
            masked_irq_status_q <= raw_d & irq_mask_reg;
            irq_q <= |(raw_d & irq_mask_reg);
            // Separate sticky words, event beats clear
            fifo_overflow_status_q <= (fifo_overflow_status_q & ~ovf_clr) | ovf_ev;
            fifo_underflow_status_q <= (fifo_underflow_status_q & ~udf_clr) | udf_ev;
        end
    end
endmodule

// ### verification/asq_conv_model.sv
// Behavioural converter core answering conversion requests.
// Assumes one request at a time; latency lat (at least 1) set by the bench.
module asq_conv_model
    import asq_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] lat,
    input wire logic conv_start,
    input wire logic [3:0] conv_input_q,
    input wire logic conv_diff_q,
    input wire logic conv_temp_q,
    output logic conv_done,
    output asq_sample_t conv_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] cnt_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            conv_done <= 1'b0;
            conv_data <= '0;
        end else begin
            conv_done <= (cnt_q == 4'h1);
            // Data valid only with conv_done
            conv_data <= (cnt_q == 4'h1) ? {4'h5, conv_temp_q, conv_diff_q, conv_input_q}
                : ~conv_data;
            cnt_q <= conv_start ? lat : ((cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0);
        end
    end
endmodule

// ### verification/asq_seq_monitor.sv
// Port checker for the sample sequencer control block.
// Assumes bind onto asq_sequencer_top and one clock domain.
module asq_seq_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [3:0] active_sequencer_enable,
    input wire logic pri_wr,
    input wire logic [15:0] pri_wdata,
    input wire logic irq_clr_wr,
    input wire logic [3:0] masked_irq_status_clear,
    input wire logic ovf_clr_wr,
    input wire logic [3:0] ovf_clr_bits,
    input wire logic loopback_test_control,
    input wire logic conv_start,
    input wire logic [3:0][31:0] seq_result_fifo,
    input wire logic [3:0][31:0] seq_fifo_status_q,
    input wire logic [15:0] sequencer_priority_q,
    input wire logic [3:0] raw_irq_status_q,
    input wire logic [3:0] masked_irq_status_q,
    input wire logic irq_q,
    input wire logic [3:0] fifo_overflow_status_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_masked_subset: assert property ((masked_irq_status_q & ~raw_irq_status_q) == 4'h0)
        else $error("masked status outside raw");
    chk_irq_or: assert property (irq_q == |masked_irq_status_q)
        else $error("irq differs from masked status");
    chk_raw_sticky: assert property (ce |=> ($past(raw_irq_status_q) & ~raw_irq_status_q
        & ~($past(masked_irq_status_clear) & {4{$past(irq_clr_wr)}})) == 4'h0)
        else $error("raw bit fell without a clear");
    chk_ovf_sticky: assert property (ce |=> ($past(fifo_overflow_status_q)
        & ~fifo_overflow_status_q & ~($past(ovf_clr_bits) & {4{$past(ovf_clr_wr)}})) == 4'h0)
        else $error("overflow bit fell without a clear");
    chk_start_single: assert property (conv_start |=> !conv_start)
        else $error("start longer than one cycle");
    chk_start_enabled: assert property (conv_start |-> $past(active_sequencer_enable) != 4'h0)
        else $error("start with no sequencer enabled");
    chk_loop_quiet: assert property (conv_start |-> !loopback_test_control)
        else $error("converter used in loopback");
    chk_pri_write: assert property (pri_wr && ce |=>
        (sequencer_priority_q & 16'h3333) == ($past(pri_wdata) & 16'h3333))
        else $error("priority write lost");
    chk_word_upper: assert property ({seq_result_fifo[0][31:10], seq_result_fifo[1][31:10],
        seq_result_fifo[2][31:10], seq_result_fifo[3][31:10]} == 88'h0)
        else $error("result word upper bits set");
    chk_full_empty: assert property (!(seq_fifo_status_q[0][12] && seq_fifo_status_q[0][8]))
        else $error("buffer full and empty at once");
    cover property (irq_q);
    cover property (conv_start ##1 !conv_start);
    cover property (fifo_overflow_status_q != 4'h0);
endmodule
bind asq_sequencer_top asq_seq_monitor u_mon (.*);

// ### verification/testbench.sv
// Self-checking bench for the sample sequencer control block.
// Assumes the converter model answers after lat cycles.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import asq_pkg::*;
    logic ref_clk, rst, ce, pri_wr, init_wr, irq_clr_wr, ovf_clr_wr, udf_clr_wr, busy;
    logic loopback_test_control, conv_done, conv_start, conv_diff_q, conv_temp_q, irq_q;
    logic [3:0] active_sequencer_enable, irq_mask_reg, processor_initiate, lat;
    logic [3:0] masked_irq_status_clear, ovf_clr_bits, udf_clr_bits, fifo_pop, ext_event;
    logic [3:0] conv_input_q, raw_irq_status_q, masked_irq_status_q;
    logic [3:0] fifo_overflow_status_q, fifo_underflow_status_q;
    logic [15:0] trigger_event_select, pri_wdata, sequencer_priority_q;
    logic [3:0][31:0] seq_input_select, seq_sample_control, seq_result_fifo, seq_fifo_status_q;
    logic [2:0] averaging_control;
    asq_sample_t conv_data;
    logic [3:0] ins[$];
    int fails, checks_done, starts;
    asq_sequencer_top DUT (.*);
    asq_conv_model u_core (.*);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        if (conv_start === 1'b1) begin
            starts <= starts + 1;
            ins.push_back(conv_input_q);
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task finish_test;
        if (fails == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task kick(input logic [3:0] m);
        @(posedge ref_clk);
        starts = 0;
        ins = {};
        init_wr <= 1'b1;
        processor_initiate <= m;
        @(posedge ref_clk);
        init_wr <= 1'b0;
    endtask
    task wait_idle;
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk);
        if (busy !== 1'b0) begin
            fails++;
            finish_test;
        end
        repeat (2) @(posedge ref_clk);
    endtask
    task pop(input int n, input logic [31:0] exp);
        @(posedge ref_clk);
        fifo_pop[n] <= 1'b1;
        @(posedge ref_clk);
        fifo_pop[n] <= 1'b0;
        #1 chk(seq_result_fifo[n], exp);
    endtask
    task t_seq0;
        seq_input_select[0] <= 32'h3333_3333;
        seq_sample_control[0] <= 32'h0000_E2C1;
        irq_mask_reg <= 4'h1;
        kick(4'h1);
        repeat (6) @(posedge ref_clk);
        chk(starts, 0);
        active_sequencer_enable <= 4'h1;
        kick(4'h1);
        wait_idle;
        chk(starts, 3);
        chk({seq_fifo_status_q[0][12], seq_fifo_status_q[0][8],
            seq_fifo_status_q[0][7:4] + seq_fifo_status_q[0][3:0]}, 6'h03);
        chk({irq_q, masked_irq_status_q, raw_irq_status_q}, 9'h111);
        pop(0, 32'h0000_0153);
        pop(0, 32'h0000_0163);
        pop(0, 32'h0000_0143);
        pop(0, 32'h0000_0143);
        chk(fifo_underflow_status_q, 4'h1);
        @(posedge ref_clk);
        irq_clr_wr <= 1'b1;
        masked_irq_status_clear <= 4'h0;
        @(posedge ref_clk);
        masked_irq_status_clear <= 4'h1;
        #1 chk(raw_irq_status_q, 4'h1);
        @(posedge ref_clk);
        irq_clr_wr <= 1'b0;
        #1 chk({irq_q, raw_irq_status_q}, 5'h00);
    endtask
    task t_pri;
        @(posedge ref_clk);
        active_sequencer_enable <= 4'h6;
        seq_input_select[1] <= 32'h0000_0001;
        seq_input_select[2] <= 32'h0000_0002;
        seq_sample_control[1] <= 32'h0000_0002;
        seq_sample_control[2] <= 32'h0000_0002;
        pri_wr <= 1'b1;
        pri_wdata <= 16'h3021;
        @(posedge ref_clk);
        pri_wr <= 1'b0;
        kick(4'h6);
        wait_idle;
        chk(sequencer_priority_q, 16'h3021);
        chk({ins[0], ins[1]}, 8'h21);
    endtask
    task t_ext;
        trigger_event_select <= 16'h0010;
        starts = 0;
        ext_event <= 4'h1;
        repeat (3) @(posedge ref_clk);
        wait_idle;
        chk(starts, 1);
        ext_event <= 4'h0;
    endtask
    task t_avg_loop;
        active_sequencer_enable <= 4'h8;
        seq_input_select[3] <= 32'h0000_0007;
        seq_sample_control[3] <= 32'h0000_0006;
        averaging_control <= 3'h2;
        lat <= 4'h5;
        kick(4'h8);
        wait_idle;
        chk(starts, 4);
        pop(3, 32'h0000_0147);
        averaging_control <= 3'h0;
        loopback_test_control <= 1'b1;
        kick(4'h8);
        wait_idle;
        chk({starts[3:0], seq_fifo_status_q[3][8]}, 5'h00);
    endtask
    task t_ovf;
        loopback_test_control <= 1'b0;
        trigger_event_select <= 16'hF000;
        kick(4'h0);
        repeat (40) @(posedge ref_clk);
        active_sequencer_enable <= 4'h0;
        repeat (3) @(posedge ref_clk);
        chk({fifo_overflow_status_q, seq_fifo_status_q[3][12]}, 5'h11);
        chk(starts > 3, 1);
        ovf_clr_wr <= 1'b1;
        ovf_clr_bits <= 4'h8;
        @(posedge ref_clk);
        ovf_clr_wr <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk(fifo_overflow_status_q, 4'h0);
    endtask
    initial begin
        {rst, ce, lat, ext_event, udf_clr_wr, udf_clr_bits} = {1'b1, 1'b1, 4'h1, 9'h000};
        {pri_wr, init_wr, irq_clr_wr, ovf_clr_wr, loopback_test_control} = 5'h00;
        {active_sequencer_enable, irq_mask_reg, processor_initiate, fifo_pop} = 16'h0000;
        {masked_irq_status_clear, ovf_clr_bits, averaging_control} = 11'h000;
        {trigger_event_select, pri_wdata, starts} = '0;
        seq_input_select = '0;
        seq_sample_control = '0;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 chk(sequencer_priority_q, 16'h3210);
        chk(seq_fifo_status_q[3], 32'h0000_0100);
        t_seq0;
        t_pri;
        t_ext;
        t_avg_loop;
        t_ovf;
        finish_test;
    end
endmodule
